// ===== core/sspr_pkg.sv
package sspr_pkg;
    // Register byte addresses on the APB
    localparam logic [11:0] SSPR_ADDR_PORT_STATUS    = 12'h000;
    localparam logic [11:0] SSPR_ADDR_CLOCK_PRESCALE = 12'h004;

    // Field positions in port_status
    localparam int SSPR_BUSY_BIT        = 4;
    localparam int SSPR_RX_FULL_BIT     = 3;
    localparam int SSPR_RX_NONEMPTY_BIT = 2;
    localparam int SSPR_TX_NOT_FULL_BIT = 1;
    localparam int SSPR_TX_EMPTY_BIT    = 0;
    localparam int SSPR_STATUS_WIDTH    = 5;

    // Field layout of clock_prescale
    localparam int SSPR_DIVISOR_MSB = 7;
    localparam int SSPR_DIVISOR_LSB = 0;
    localparam int SSPR_DIVISOR_WIDTH = 8;

    // Reset values
    localparam logic [4:0] SSPR_STATUS_RESET  = 5'h01;
    localparam logic [7:0] SSPR_DIVISOR_RESET = 8'h00;

    // Divisors below this leave the prescaler stopped
    localparam logic [7:0] SSPR_DIVISOR_MIN = 8'h02;

    // Cycles that a link edge keeps the activity flag up
    localparam int SSPR_LINK_HOLD_CYCLES = 4;

    localparam logic [31:0] SSPR_DATA_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        SSPR_APB_IDLE,
        SSPR_APB_WAIT,
        SSPR_APB_DONE
    } sspr_apb_state_type;
endpackage : sspr_pkg

// ===== core/sspr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sspr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds the second stage only
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : sspr_sync
`default_nettype wire

// ===== core/sspr_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module sspr_prescaler
    import sspr_pkg::*;
(
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_divisor,
    output logic            o_base_tick,
    output logic            o_base_clk
);
    logic [7:0] count_reg;
    logic [7:0] half_reg;
    logic       run;

    assign run = (i_divisor >= SSPR_DIVISOR_MIN);

    // Even divisor N: tick every N cycles, square wave high for N/2 of them
    always_ff @(posedge i_core_clk) begin
        if (i_rst || !run) begin
            count_reg   <= 8'h00;
            o_base_tick <= 1'b0;
            o_base_clk  <= 1'b0;
        end else if (count_reg >= i_divisor - 8'h01) begin
            count_reg   <= 8'h00;
            o_base_tick <= 1'b1;
            o_base_clk  <= 1'b0;
        end else begin
            count_reg   <= count_reg + 8'h01;
            o_base_tick <= 1'b0;
            o_base_clk  <= (count_reg + 8'h01 >= half_reg);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            half_reg <= 8'h00;
        end else begin
            half_reg <= {1'b0, i_divisor[7:1]};
        end
    end
endmodule : sspr_prescaler
`default_nettype wire

// ===== core/sspr_status_prescale.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sspr_status_prescale (
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // FIFO and shifter state, same clock
    input  wire logic        i_tx_fifo_empty,
    input  wire logic        i_tx_fifo_full,
    input  wire logic        i_rx_fifo_empty,
    input  wire logic        i_rx_fifo_full,
    input  wire logic        i_shift_busy,
    // Link side
    input  wire logic        i_link_clk,
    input  wire logic        i_link_sel_n,
    // Prescaler outputs and the registered divisor
    output logic             o_base_tick,
    output logic             o_base_clk,
    output logic      [7:0]  o_prescale_divisor
);
    import sspr_pkg::*;

    sspr_apb_state_type apb_state_reg;
    logic [SSPR_STATUS_WIDTH-1:0]  status_reg;
    logic [SSPR_STATUS_WIDTH-1:0]  status_next;
    logic [SSPR_DIVISOR_WIDTH-1:0] divisor_reg;
    logic                          link_rst;
    logic                          link_sel_sync_n;
    logic                          link_toggle_reg;
    logic                          link_toggle_sync;
    logic                          link_toggle_seen_reg;
    logic [2:0]                    link_hold_reg;
    logic                          frame_active;
    logic                          access;
    logic                          write_hit;

    function automatic logic addr_mapped(input logic [11:0] addr);
        addr_mapped = (addr == SSPR_ADDR_PORT_STATUS) || (addr == SSPR_ADDR_CLOCK_PRESCALE);
    endfunction : addr_mapped

    // Link domain: reset brought over, toggle per link edge inside a frame
    sspr_sync #(.WIDTH(1)) u_link_rst_sync (
        .i_clk   (i_link_clk),
        .i_rst   (1'b0),
        .i_async (i_rst),
        .o_sync  (link_rst)
    );

    always_ff @(posedge i_link_clk) begin
        if (link_rst) begin
            link_toggle_reg <= 1'b0;
        end else if (!i_link_sel_n) begin
            link_toggle_reg <= ~link_toggle_reg;
        end
    end

    // Pin and link toggle enter the core domain through two flops each
    sspr_sync #(.WIDTH(1)) u_sel_sync (
        .i_clk   (i_core_clk),
        .i_rst   (i_rst),
        .i_async (~i_link_sel_n),
        .o_sync  (link_sel_sync_n)
    );

    sspr_sync #(.WIDTH(1)) u_toggle_sync (
        .i_clk   (i_core_clk),
        .i_rst   (i_rst),
        .i_async (link_toggle_reg),
        .o_sync  (link_toggle_sync)
    );

    // Each link edge keeps activity up for a few core cycles
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            link_toggle_seen_reg <= 1'b0;
            link_hold_reg        <= 3'd0;
        end else begin
            link_toggle_seen_reg <= link_toggle_sync;
            if (link_toggle_sync != link_toggle_seen_reg) begin
                link_hold_reg <= 3'(SSPR_LINK_HOLD_CYCLES);
            end else if (link_hold_reg != 3'd0) begin
                link_hold_reg <= link_hold_reg - 3'd1;
            end
        end
    end

    // link_sel_sync_n carries the active-high frame select after sync
    assign frame_active = link_sel_sync_n || (link_hold_reg != 3'd0) || i_shift_busy;

    always_comb begin
        status_next                       = '0;
        status_next[SSPR_BUSY_BIT]        = frame_active || !i_tx_fifo_empty;
        status_next[SSPR_RX_FULL_BIT]     = i_rx_fifo_full;
        status_next[SSPR_RX_NONEMPTY_BIT] = !i_rx_fifo_empty;
        status_next[SSPR_TX_NOT_FULL_BIT] = !i_tx_fifo_full;
        status_next[SSPR_TX_EMPTY_BIT]    = i_tx_fifo_empty;
    end

    // Status follows hardware only; bus writes never reach it
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            status_reg <= SSPR_STATUS_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // APB: setup, two wait cycles, then pready with data
    // The write lands at the edge where the master samples pready high
    assign access    = i_psel && i_penable;
    assign write_hit = (apb_state_reg == SSPR_APB_DONE) && access && i_pwrite
                       && (i_paddr == SSPR_ADDR_CLOCK_PRESCALE);

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            apb_state_reg <= SSPR_APB_IDLE;
        end else begin
            unique case (apb_state_reg)
                SSPR_APB_IDLE: begin
                    if (access) begin
                        apb_state_reg <= SSPR_APB_WAIT;
                    end
                end
                SSPR_APB_WAIT: begin
                    apb_state_reg <= SSPR_APB_DONE;
                end
                SSPR_APB_DONE: begin
                    apb_state_reg <= SSPR_APB_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready  <= (apb_state_reg == SSPR_APB_WAIT);
            o_pslverr <= (apb_state_reg == SSPR_APB_WAIT) && !addr_mapped(i_paddr);
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prdata <= SSPR_DATA_ZERO;
        end else if (apb_state_reg == SSPR_APB_WAIT && !i_pwrite) begin
            o_prdata <= SSPR_DATA_ZERO;
            if (i_paddr == SSPR_ADDR_PORT_STATUS) begin
                o_prdata[SSPR_STATUS_WIDTH-1:0] <= status_reg;
            end else if (i_paddr == SSPR_ADDR_CLOCK_PRESCALE) begin
                o_prdata[SSPR_DIVISOR_MSB:SSPR_DIVISOR_LSB] <= divisor_reg;
            end
        end else begin
            o_prdata <= SSPR_DATA_ZERO;
        end
    end

    // Divisor stored with bit 0 forced low; range is software's duty
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            divisor_reg <= SSPR_DIVISOR_RESET;
        end else if (write_hit) begin
            divisor_reg <= {i_pwdata[SSPR_DIVISOR_MSB:SSPR_DIVISOR_LSB+1], 1'b0};
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            o_prescale_divisor <= SSPR_DIVISOR_RESET;
        end else begin
            o_prescale_divisor <= divisor_reg;
        end
    end

    sspr_prescaler u_prescaler (
        .i_core_clk  (i_core_clk),
        .i_rst       (i_rst),
        .i_divisor   (divisor_reg),
        .o_base_tick (o_base_tick),
        .o_base_clk  (o_base_clk)
    );
endmodule : sspr_status_prescale
`default_nettype wire

// ===== verification/sspr_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sspr_sva
    import sspr_pkg::*;
(
    input wire logic        i_core_clk,
    input wire logic        i_rst,
    input wire logic        i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    input wire logic        i_tx_fifo_empty,
    input wire logic        i_tx_fifo_full,
    input wire logic        i_rx_fifo_empty,
    input wire logic        i_rx_fifo_full,
    input wire logic        i_shift_busy,
    input wire logic        o_base_tick,
    input wire logic [7:0]  o_prescale_divisor
);
    logic [1:0] calm;
    logic [8:0] gap;
    logic       seen;
    wire logic [4:0] fin = {i_tx_fifo_empty, i_tx_fifo_full, i_rx_fifo_empty, i_rx_fifo_full, i_shift_busy};
    wire logic rd_st = o_pready && !i_pwrite && i_paddr == SSPR_ADDR_PORT_STATUS && calm == 2'h3;
    // Flags are judged only once the inputs have been still long enough to pass the registers
    always_ff @(posedge i_core_clk) begin
        calm <= (i_rst || !$stable(fin)) ? 2'h0 : calm + {1'b0, calm != 2'h3};
        gap  <= o_base_tick ? 9'h001 : gap + 9'h001;
        seen <= (i_rst || !$stable(o_prescale_divisor)) ? 1'b0 : (seen || o_base_tick);
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    sequence s_pre_wr;
        o_pready && i_pwrite && !o_pslverr && i_paddr == SSPR_ADDR_CLOCK_PRESCALE;
    endsequence
    a_busy_flag_set: assert property (rd_st && (!i_tx_fifo_empty || i_shift_busy) |-> o_prdata[4])
        else $error("busy flag low");
    a_rx_full_flag: assert property (rd_st |-> o_prdata[3] == i_rx_fifo_full)
        else $error("rx full flag");
    a_rx_nonempty_flag: assert property (rd_st |-> o_prdata[2] != i_rx_fifo_empty)
        else $error("rx nonempty flag");
    a_tx_not_full: assert property (rd_st |-> o_prdata[1] != i_tx_fifo_full)
        else $error("tx not full flag");
    a_tx_empty_flag: assert property (rd_st |-> o_prdata[0] == i_tx_fifo_empty)
        else $error("tx empty flag");
    a_divisor_even: assert property (s_pre_wr |=> ##1 o_prescale_divisor == {$past(i_pwdata[7:1], 2), 1'b0})
        else $error("divisor write");
    a_tick_period: assert property (o_base_tick && seen && $stable(o_prescale_divisor)
        && o_prescale_divisor > 8'h01 |-> gap == {1'b0, o_prescale_divisor}) else $error("tick period");
    a_status_wr_ignored: assert property (o_pready && i_pwrite && i_paddr == SSPR_ADDR_PORT_STATUS
        |=> $stable(o_prescale_divisor) [*2]) else $error("status write");
endmodule : sspr_sva
bind sspr_status_prescale sspr_sva sspr_sva_i (.i_core_clk, .i_rst, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_tx_fifo_empty, .i_tx_fifo_full, .i_rx_fifo_empty, .i_rx_fifo_full, .i_shift_busy,
    .o_base_tick, .o_prescale_divisor);
`default_nettype wire

// ===== verification/sspr_link_peer.sv
`timescale 1ns/1ps
`default_nettype none
module sspr_link_peer (
    output var logic o_link_clk,
    output var logic o_link_sel_n
);
    // Clock stands low and select rests high outside frames
    initial begin
        o_link_clk   = 1'b0;
        o_link_sel_n = 1'b1;
    end
    // Peer drives the link clock, so the block sits in the slave role
    task automatic frame(input int bits);
        #13 o_link_sel_n = 1'b0;
        repeat (bits) begin
            #40 o_link_clk = 1'b1;
            #40 o_link_clk = 1'b0;
        end
        #40 o_link_sel_n = 1'b1;
    endtask : frame
endmodule : sspr_link_peer
`default_nettype wire

// ===== verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sspr_pkg::*;
    typedef struct packed {logic [4:0] fin; logic [4:0] st;} sspr_row_type;
    localparam sspr_row_type ROWS [4] = '{'{5'h14, 5'h03}, '{5'h0A, 5'h1C}, '{5'h11, 5'h17}, '{5'h04, 5'h12}};
    localparam logic [7:0] DIVS [3] = '{8'h02, 8'h33, 8'hFE};
    logic        i_core_clk = 1'b0;
    logic        i_rst      = 1'b1;
    logic        psel       = 1'b0;
    logic        penable    = 1'b0;
    logic        pwrite     = 1'b0;
    logic [11:0] paddr      = 12'h000;
    logic [31:0] pwdata     = 32'h0000_0000;
    logic [4:0]  fin        = 5'h14;
    logic [31:0] prdata, r;
    logic        pready, pslverr, e, tick, link_clk, link_sel_n;
    int          num_errors = 0;
    int          n_checks   = 0;
    int          p;
    sspr_status_prescale sspr_status_prescale_i (.i_core_clk, .i_rst, .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_tx_fifo_empty(fin[4]), .i_tx_fifo_full(fin[3]), .i_rx_fifo_empty(fin[2]),
        .i_rx_fifo_full(fin[1]), .i_shift_busy(fin[0]), .i_link_clk(link_clk), .i_link_sel_n(link_sel_n),
        .o_base_tick(tick), .o_base_clk(), .o_prescale_divisor());
    sspr_link_peer sspr_link_peer_i (.o_link_clk(link_clk), .o_link_sel_n(link_sel_n));
    task automatic end_of_test;
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge i_core_clk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge i_core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge i_core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'h0;
        if (n == 20) begin
            num_errors++;
            end_of_test();
        end
    endtask : apb
    task automatic period;
        int n;
        n = 0;
        repeat (2) begin
            @(posedge i_core_clk);
            for (; tick !== 1'b1 && n < 900; n++) @(posedge i_core_clk);
        end
        for (p = 1; p < 600; p++) begin
            @(posedge i_core_clk);
            if (tick === 1'b1) break;
        end
        if (n == 900 || p == 600) begin
            num_errors++;
            end_of_test();
        end
    endtask : period
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        foreach (ROWS[k]) begin
            fin <= ROWS[k].fin;
            apb(1'b1, SSPR_ADDR_PORT_STATUS, 32'hFFFF_FFFF);
            apb(1'b0, SSPR_ADDR_PORT_STATUS, 32'h0000_0000);
            chk(r, {27'h000_0000, ROWS[k].st});
        end
        foreach (DIVS[k]) begin
            apb(1'b1, SSPR_ADDR_CLOCK_PRESCALE, {24'h00_0000, DIVS[k]});
            apb(1'b0, SSPR_ADDR_CLOCK_PRESCALE, 32'h0000_0000);
            chk(r, {24'h00_0000, DIVS[k] & 8'hFE});
            period();
            chk(32'(p), {24'h00_0000, DIVS[k] & 8'hFE});
        end
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(r, 32'h0000_0000);
        chk({31'h0000_0000, e}, 32'h0000_0001);
        fin <= 5'h14;
        fork
            sspr_link_peer_i.frame(16);
            begin
                repeat (30) @(posedge i_core_clk);
                apb(1'b0, SSPR_ADDR_PORT_STATUS, 32'h0000_0000);
                chk(r, 32'h0000_0013);
            end
        join
        repeat (20) @(posedge i_core_clk);
        apb(1'b0, SSPR_ADDR_PORT_STATUS, 32'h0000_0000);
        chk(r, 32'h0000_0003);
        i_rst <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        apb(1'b0, SSPR_ADDR_PORT_STATUS, 32'h0000_0000);
        chk(r, 32'h0000_0003);
        apb(1'b0, SSPR_ADDR_CLOCK_PRESCALE, 32'h0000_0000);
        chk(r, {24'h00_0000, SSPR_DIVISOR_RESET});
        end_of_test();
    end
endmodule : tb
`default_nettype wire
